/* File: testbench/spif_core_test.sv */
// Self-checking bench of the serial engine, its queues and its pin routing.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module spif_core_test;
  import spif_pkg::*;
  logic            clk_sys, nrst, mode_fault_clear, tx_valid, tx_ready, rx_valid, rx_ready;
  logic            tb_sck, tb_mosi, tb_miso, tb_ss_n, peer_miso, peer_oe, peer_en, sck_prev;
  logic [15:0]     tx_data, rx_data, got, reply;
  logic [7:0]      q8;
  logic [4:0]      bits;
  spif_ctrl_type   ctrl;
  spif_power_type  power;
  spif_pins_type   pin_in, pin_out, pin_oe, pin_owned;
  spif_status_type status;
  int              fail_count = 0, comparisons = 0, toggles = 0, n, k;

  // ****************************************************************
  // Wires, design and far side
  // ****************************************************************
  // A released MISO line shows a changing pattern rather than a stale level; the other lines show the bench's driven levels.
  assign pin_in.sck  = pin_oe.sck ? pin_out.sck : tb_sck;
  assign pin_in.mosi = pin_oe.mosi ? pin_out.mosi : tb_mosi;
  assign pin_in.miso = pin_oe.miso ? pin_out.miso : (peer_oe ? peer_miso : tb_miso);
  assign pin_in.ss_n = pin_oe.ss_n ? pin_out.ss_n : tb_ss_n;

  spif_core #(.SCK_HALF(4), .FIFO_DEPTH(4)) dut_u (.clk_sys, .nrst, .ctrl, .power,
    .mode_fault_clear, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready,
    .pin_in, .pin_out, .pin_oe, .pin_owned, .status);
  spif_peer peer_u (.en(peer_en), .cpol(ctrl.clk_polarity), .bits, .reply, .sck(pin_in.sck),
    .mosi(pin_in.mosi), .ss_n(pin_in.ss_n), .miso(peer_miso), .oe(peer_oe), .got);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    tb_miso <= ~tb_miso;
    sck_prev <= pin_in.sck;
    if (sck_prev !== pin_in.sck) toggles <= toggles + 1;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic print_verdict;
    $display("counts: %0d compared, %0d bad", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task automatic tick(int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic cfg(logic m, logic w16, logic pol, logic q);
    ctrl = '0;
    ctrl.module_enable = 1'b1;
    ctrl.master_mode = m;
    ctrl.clk_polarity = pol;
    ctrl.word_length_select = w16;
    ctrl.mode_fault_enable = 1'b1;
    ctrl.select_output_enable = 1'b1;
    ctrl.queue_mode_enable = q;
    ctrl.clock_gate_register = 1'b1;
    tick(2);
  endtask : cfg

  task automatic wr(logic [15:0] d);
    int i;
    tx_data = d;
    tx_valid = 1'b1;
    for (i = 0; i < 200 && tx_ready !== 1'b1; i++) @(negedge clk_sys);
    if (i == 200) begin fail_count++; print_verdict; end
    tick(1);
    tx_valid = 1'b0;
  endtask : wr

  task automatic rd(logic [15:0] e);
    int i;
    for (i = 0; i < 4000 && rx_valid !== 1'b1; i++) @(negedge clk_sys);
    if (i == 4000) begin fail_count++; print_verdict; end
    `CHK(rx_data, e)
    tick(1);
    `CHK(status.rx_full, 1'b1)
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
  endtask : rd

  // The link clock runs at 125 ns and is unrelated in phase to the system clock.
  task automatic sx(logic [7:0] d, logic sel, output logic [7:0] q);
    tb_ss_n = !sel;
    #100;
    for (int i = 7; i >= 0; i--) begin
      tb_mosi = d[i];
      #62.5 tb_sck = 1'b1;
      q[i] = pin_in.miso;
      #62.5 tb_sck = 1'b0;
    end
    #100 tb_ss_n = 1'b1;
    tick(1);
  endtask : sx

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    nrst = 1'b0;
    ctrl = '0;
    ctrl.clock_gate_register = 1'b1;
    power = '0;
    {mode_fault_clear, tx_valid, rx_ready, tb_sck, tb_mosi, tb_miso, peer_en} = 7'h00;
    tb_ss_n = 1'b1;
    tx_data = 16'h0000;
    bits = 5'h08;
    reply = 16'h0000;
    tick(2);
    nrst = 1'b1;
    tick(2);
    `CHK(tx_ready, 1'b1)
    for (k = 0; k < 4; k++) begin
      cfg(1'b1, k == 1, k == 1, 1'b0);
      bits = (k == 1) ? 5'h10 : 5'h08;
      reply = 16'h3c96 ^ k;
      peer_en = 1'b1;
      power.wait_mode = (k == 1);
      `CHK(pin_out.sck, ctrl.clk_polarity)
      wr(16'ha55a + k);
      for (n = 0; n < 100 && status.busy !== 1'b1; n++) tick(1);
      if (n == 100) begin fail_count++; print_verdict; end
      `CHK(pin_out.ss_n, 1'b0)
      if (k >= 2) begin
        tick(10);
        power.wait_mode = (k == 2);
        ctrl.stop_in_wait = (k == 2);
        power.stop_light = (k == 3);
        tick(4);
        n = toggles;
        tick(40);
        `CHK(toggles, n)
        power = '0;
        ctrl.stop_in_wait = 1'b0;
      end
      rd((k == 1) ? reply : {8'h00, reply[7:0]});
      `CHK(got, (k == 1) ? 16'ha55b : {8'h00, 8'h5a + k[7:0]})
      power = '0;
      $display("test master %0d done", k);
    end
    peer_en = 1'b0;
    for (k = 0; k < 2; k++) begin
      cfg(1'b0, 1'b0, 1'b0, 1'b0);
      wr(16'h005a + k);
      power.wait_mode = (k == 0);
      ctrl.stop_in_wait = (k == 0);
      power.stop_light = (k == 1);
      sx(8'hff, 1'b0, q8);
      sx(8'h96, 1'b1, q8);
      `CHK(q8, 8'h5a + k)
      rd(16'h0096);
      power = '0;
      $display("test slave %0d done", k);
    end
    ctrl.module_enable = 1'b0;
    tick(3);
    `CHK(pin_owned, 4'h0)
    cfg(1'b1, 1'b0, 1'b0, 1'b0);
    ctrl.bidir_pin_control = 1'b1;
    ctrl.mode_fault_enable = 1'b0;
    tick(3);
    `CHK(pin_owned.miso, 1'b0)
    `CHK(pin_owned.ss_n, 1'b0)
    `CHK(pin_oe.mosi, 1'b0)
    ctrl.bidir_output_enable = 1'b1;
    tick(3);
    `CHK(pin_oe.mosi, 1'b1)
    cfg(1'b0, 1'b0, 1'b0, 1'b0);
    ctrl.bidir_pin_control = 1'b1;
    tick(3);
    `CHK(pin_owned.mosi, 1'b0)
    `CHK(pin_owned.miso, 1'b1)
    cfg(1'b1, 1'b0, 1'b0, 1'b0);
    ctrl.select_output_enable = 1'b0;
    tb_ss_n = 1'b0;
    tick(5);
    `CHK(status.mode_fault, 1'b1)
    `CHK(status.busy, 1'b0)
    tb_ss_n = 1'b1;
    mode_fault_clear = 1'b1;
    tick(5);
    mode_fault_clear = 1'b0;
    `CHK(status.mode_fault, 1'b0)
    $display("test pins done");
    for (k = 0; k < 2; k++) begin
      cfg(1'b0, 1'b0, 1'b0, k == 1);
      tx_valid = 1'b1;
      n = 0;
      repeat (12) begin
        @(negedge clk_sys);
        if (tx_ready === 1'b1) n++;
      end
      tick(1);
      tx_valid = 1'b0;
      `CHK(n, (k == 1) ? 4 : 1)
      if (k == 1) `CHK(status.tx_full, 1'b1)
      `CHK(status.tx_empty, 1'b0)
      power.stop_deep = 1'b1;
      tick(2);
      power.stop_deep = 1'b0;
      tick(2);
      `CHK(status.tx_empty, 1'b1)
      `CHK(status.tx_full, 1'b0)
    end
    ctrl.clock_gate_register = 1'b0;
    tx_valid = 1'b1;
    tick(3);
    tx_valid = 1'b0;
    ctrl.clock_gate_register = 1'b1;
    tick(2);
    `CHK(status.tx_empty, 1'b1)
    $display("test queue done");
    print_verdict;
  end
endmodule : spif_core_test

`default_nettype wire

/* File: testbench/spif_peer.sv */
// Behavioural far-side slave that answers the block when it is master.
`timescale 1ns/1ps
`default_nettype none

module spif_peer (
  input  wire logic        en,
  input  wire logic        cpol,
  input  wire logic [4:0]  bits,
  input  wire logic [15:0] reply,
  input  wire logic        sck,
  input  wire logic        mosi,
  input  wire logic        ss_n,
  output logic             miso,
  output logic             oe,
  output logic [15:0]      got
);
  logic [15:0] sh;

  initial begin
    sh = 16'h0000;
    got = 16'h0000;
    miso = 1'b0;
  end

  // Drives its data line only while selected, so a released line is not mistaken for data.
  assign oe = en && !ss_n;

  always @(negedge ss_n) begin
    sh = reply << (5'h10 - bits);
    got = 16'h0000;
    miso = sh[15];
  end

  // Samples on the leading edge and shifts on the trailing one.
  always @(sck) begin
    if (oe && (sck != cpol)) begin
      got = {got[14:0], mosi};
    end else if (oe) begin
      sh = {sh[14:0], 1'b0};
      miso = sh[15];
    end
  end
endmodule : spif_peer

`default_nettype wire

/* File: verilog/spif_core.sv */
// Serial peripheral engine with transmit and receive queues and pin routing.
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Queue
// ****************************************************************
module spif_fifo #(
  parameter int unsigned W  = 16,
  parameter int unsigned D  = 4,
  parameter int unsigned AW = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         clear,
  input  wire logic         one_deep,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(D);
  localparam logic [AW:0] ONE_C   = (AW+1)'(1);

  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  logic [AW:0]   cnt_next;
  logic          push;
  logic          pop;

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem_reg[rd_reg];

  always_comb begin
    cnt_next = cnt_reg;
    if (clear) begin
      cnt_next = '0;
    end else if (push && !pop) begin
      cnt_next = cnt_reg + ONE_C;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - ONE_C;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_reg   <= '0;
      wr_reg    <= '0;
      rd_reg    <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      // Outside queue mode one word is held, which is the plain double buffer.
      in_ready  <= cnt_next < (one_deep ? ONE_C : DEPTH_C);
      out_valid <= cnt_next != '0;
      if (clear) begin
        wr_reg <= '0;
        rd_reg <= '0;
      end else begin
        if (push) begin
          wr_reg <= (wr_reg == AW'(D - 1)) ? '0 : wr_reg + AW'(1);
        end
        if (pop) begin
          rd_reg <= (rd_reg == AW'(D - 1)) ? '0 : rd_reg + AW'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push && !clear) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
endmodule : spif_fifo

module spif_core #(
  parameter int unsigned SCK_HALF   = spif_pkg::SPIF_SCK_HALF_CYC,
  parameter int unsigned FIFO_DEPTH = spif_pkg::SPIF_FIFO_DEPTH
) (
  input  wire logic                         clk_sys,
  input  wire logic                         nrst,
  input  wire spif_pkg::spif_ctrl_type      ctrl,
  input  wire spif_pkg::spif_power_type     power,
  input  wire logic                         mode_fault_clear,
  input  wire logic [15:0]                  tx_data,
  input  wire logic                         tx_valid,
  output logic                              tx_ready,
  output logic [15:0]                       rx_data,
  output logic                              rx_valid,
  input  wire logic                         rx_ready,
  input  wire spif_pkg::spif_pins_type      pin_in,
  output spif_pkg::spif_pins_type           pin_out,
  output spif_pkg::spif_pins_type           pin_oe,
  output spif_pkg::spif_pins_type           pin_owned,
  output spif_pkg::spif_status_type         status
);
  import spif_pkg::*;

  localparam logic [7:0] HALF_LAST = 8'(SCK_HALF - 1);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [3:0]      sync1_reg;
  logic [3:0]      sync2_reg;
  logic [3:0]      sync3_reg;
  spif_pins_type   s_now;
  spif_pins_type   s_old;
  spif_state_type  state_reg;
  logic [15:0]     sh_reg;
  logic            smp_reg;
  logic [4:0]      cnt_reg;
  logic [7:0]      div_reg;
  logic            phase_reg;
  logic            fault_reg;
  spif_pins_type   out_next;
  spif_pins_type   oe_next;
  spif_pins_type   own_next;
  logic            run;
  logic            sclear;
  logic            master;
  logic            word8;
  logic [4:0]      nbits;
  logic            m_pause;
  logic            m_tick;
  logic            sel_slave;
  logic            sck_lvl;
  logic            sck_was;
  logic            ev_sample;
  logic            ev_shift;
  logic            word_done;
  logic            fault_now;
  logic            m_start;
  logic            s_start;
  logic            load;
  logic            out_bit;
  logic            din;
  logic [15:0]     sh_shift;
  logic [15:0]     rx_word;
  logic [15:0]     tq_data;
  logic            tq_valid;
  logic            tq_pop;
  logic            rx_push;
  logic            rq_ready;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 4'h1;
      sync2_reg <= 4'h1;
      sync3_reg <= 4'h1;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign s_now = sync2_reg;
  assign s_old = sync3_reg;

  // ****************************************************************
  // Mode decode and events
  // ****************************************************************
  assign run       = ctrl.clock_gate_register;
  assign sclear    = power.stop_deep || !ctrl.module_enable;
  assign master    = ctrl.master_mode;
  assign word8     = !ctrl.word_length_select;
  assign nbits     = word8 ? SPIF_BITS_BYTE : SPIF_BITS_WORD;
  // Only the master's own clock generation stops; a slave follows the pin.
  assign m_pause   = master && ((power.wait_mode && ctrl.stop_in_wait)
                     || power.stop_light);
  assign m_tick    = master && (state_reg == SPIF_ST_SHIFT) && !m_pause
                     && (div_reg == HALF_LAST);
  assign sel_slave = !master && !s_now.ss_n;
  assign sck_lvl   = s_now.sck ^ ctrl.clk_polarity;
  assign sck_was   = s_old.sck ^ ctrl.clk_polarity;
  assign ev_sample = master ? (m_tick && !phase_reg)
                   : (sel_slave && state_reg == SPIF_ST_SHIFT && sck_lvl && !sck_was);
  assign ev_shift  = master ? (m_tick && phase_reg)
                   : (sel_slave && state_reg == SPIF_ST_SHIFT && !sck_lvl && sck_was);
  assign word_done = ev_shift && (cnt_reg == nbits - 5'h01);
  assign fault_now = master && ctrl.mode_fault_enable && !ctrl.select_output_enable
                     && !s_now.ss_n;
  assign m_start   = master && state_reg == SPIF_ST_IDLE && tq_valid && !m_pause
                     && !fault_now;
  assign s_start   = state_reg == SPIF_ST_IDLE && sel_slave;
  assign load      = m_start || s_start || (word_done && sel_slave);
  assign tq_pop    = run && !sclear && load && tq_valid;
  assign out_bit   = word8 ? sh_reg[7] : sh_reg[15];
  assign sh_shift  = {sh_reg[14:0], smp_reg};
  assign rx_word   = word8 ? {8'h00, sh_shift[7:0]} : sh_shift;
  assign rx_push   = run && !sclear && word_done;

  always_comb begin
    if (master) begin
      if (ctrl.bidir_pin_control) begin
        din = ctrl.bidir_output_enable ? out_bit : s_now.mosi;
      end else begin
        din = s_now.miso;
      end
    end else begin
      if (ctrl.bidir_pin_control) begin
        din = ctrl.bidir_output_enable ? out_bit : s_now.miso;
      end else begin
        din = s_now.mosi;
      end
    end
  end

  // ****************************************************************
  // Transfer sequencer
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= SPIF_ST_IDLE;
    end else if (run) begin
      if (sclear || fault_now) begin
        state_reg <= SPIF_ST_IDLE;
      end else begin
        case (state_reg)
          SPIF_ST_IDLE: begin
            if (m_start || s_start) begin
              state_reg <= SPIF_ST_SHIFT;
            end
          end
          SPIF_ST_SHIFT: begin
            if ((master && word_done) || (!master && !sel_slave)) begin
              state_reg <= SPIF_ST_IDLE;
            end
          end
          default: begin
            state_reg <= SPIF_ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sh_reg  <= SPIF_SHIFT_RESET;
      cnt_reg <= SPIF_CNT_RESET;
      smp_reg <= 1'b0;
    end else if (run) begin
      if (sclear) begin
        sh_reg  <= SPIF_SHIFT_RESET;
        cnt_reg <= SPIF_CNT_RESET;
        smp_reg <= 1'b0;
      end else begin
        if (load) begin
          sh_reg  <= tq_valid ? tq_data : SPIF_SHIFT_RESET;
          cnt_reg <= SPIF_CNT_RESET;
        end else if (ev_shift) begin
          sh_reg  <= sh_shift;
          cnt_reg <= cnt_reg + 5'h01;
        end
        if (ev_sample) begin
          smp_reg <= din;
        end
      end
    end
  end

  // A paused master holds its divider and clock level, so the slave sees a
  // stretched clock phase and the word completes after the pause ends.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_reg   <= SPIF_DIV_RESET;
      phase_reg <= 1'b0;
    end else if (run) begin
      if (sclear || !master || state_reg != SPIF_ST_SHIFT) begin
        div_reg   <= SPIF_DIV_RESET;
        phase_reg <= 1'b0;
      end else if (!m_pause) begin
        if (div_reg == HALF_LAST) begin
          div_reg   <= SPIF_DIV_RESET;
          phase_reg <= !phase_reg;
        end else begin
          div_reg <= div_reg + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fault_reg <= 1'b0;
    end else if (run) begin
      if (sclear) begin
        fault_reg <= 1'b0;
      end else if (fault_now) begin
        fault_reg <= 1'b1;
      end else if (mode_fault_clear) begin
        fault_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Queues
  // ****************************************************************
  spif_fifo #(
    .W  (16),
    .D  (FIFO_DEPTH),
    .AW ($clog2(FIFO_DEPTH))
  ) u_txq (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .clear     (sclear),
    .one_deep  (!ctrl.queue_mode_enable),
    .in_data   (tx_data),
    .in_valid  (tx_valid && run),
    .in_ready  (tx_ready),
    .out_data  (tq_data),
    .out_valid (tq_valid),
    .out_ready (tq_pop)
  );

  // A word that finds the receive queue full is dropped, as an overrun.
  spif_fifo #(
    .W  (16),
    .D  (FIFO_DEPTH),
    .AW ($clog2(FIFO_DEPTH))
  ) u_rxq (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .clear     (sclear),
    .one_deep  (!ctrl.queue_mode_enable),
    .in_data   (rx_word),
    .in_valid  (rx_push),
    .in_ready  (rq_ready),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready && run)
  );

  // ****************************************************************
  // Pin routing
  // ****************************************************************
  always_comb begin
    out_next = SPIF_PINS_RESET;
    oe_next  = SPIF_PINS_RESET;
    own_next = SPIF_PINS_RESET;
    if (ctrl.module_enable) begin
      own_next.sck = 1'b1;
      if (master) begin
        oe_next.sck  = 1'b1;
        out_next.sck = phase_reg ^ ctrl.clk_polarity;
        own_next.mosi = 1'b1;
        out_next.mosi = out_bit;
        if (ctrl.bidir_pin_control) begin
          oe_next.mosi = ctrl.bidir_output_enable;
        end else begin
          oe_next.mosi  = 1'b1;
          own_next.miso = 1'b1;
        end
        if (ctrl.mode_fault_enable) begin
          own_next.ss_n = 1'b1;
          oe_next.ss_n  = ctrl.select_output_enable;
          out_next.ss_n = state_reg != SPIF_ST_SHIFT;
        end
      end else begin
        own_next.ss_n = 1'b1;
        own_next.miso = 1'b1;
        out_next.miso = out_bit;
        if (ctrl.bidir_pin_control) begin
          oe_next.miso = ctrl.bidir_output_enable && sel_slave;
        end else begin
          oe_next.miso  = sel_slave;
          own_next.mosi = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_out   <= SPIF_PINS_RESET;
      pin_oe    <= SPIF_PINS_RESET;
      pin_owned <= SPIF_PINS_RESET;
    end else begin
      pin_out   <= out_next;
      pin_oe    <= oe_next;
      pin_owned <= own_next;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      status <= SPIF_STATUS_RESET;
    end else begin
      status.busy       <= state_reg == SPIF_ST_SHIFT;
      status.rx_full    <= !rq_ready;
      status.tx_empty   <= !tq_valid;
      status.tx_full    <= !tx_ready;
      status.mode_fault <= fault_reg;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence master_start_s;
    run && !sclear && m_start;
  endsequence

  sequence shift_entered_s;
    state_reg == SPIF_ST_SHIFT && cnt_reg == SPIF_CNT_RESET;
  endsequence

  shift_load_a: assert property (
    master_start_s |=> shift_entered_s ##0 (sh_reg == $past(tq_data)))
    else $error("Master start did not load the transmit word.");

  word_length_a: assert property (
    rx_push |-> cnt_reg == (ctrl.word_length_select ? 5'h0f : 5'h07))
    else $error("Received word handed over at the wrong bit count.");

  master_pause_a: assert property (
    run && !sclear && m_pause && state_reg == SPIF_ST_SHIFT
    |=> $stable(div_reg) && $stable(phase_reg) && $stable(cnt_reg))
    else $error("Paused master transfer kept moving.");

  release_pins_a: assert property (
    !ctrl.module_enable |=> pin_owned == SPIF_PINS_RESET && pin_oe == SPIF_PINS_RESET)
    else $error("Disabled module still holds a pin.");

  master_bidir_a: assert property (
    ctrl.module_enable && master && ctrl.bidir_pin_control
    |=> !pin_owned.miso && pin_oe.mosi == $past(ctrl.bidir_output_enable))
    else $error("Master single wire routing wrong.");

  slave_bidir_a: assert property (
    ctrl.module_enable && !master && ctrl.bidir_pin_control
    |=> !pin_owned.mosi && pin_owned.miso && (!pin_oe.miso || $past(ctrl.bidir_output_enable)))
    else $error("Slave single wire routing wrong.");

  slave_pins_a: assert property (
    ctrl.module_enable && !master |=> !pin_oe.sck && !pin_oe.mosi)
    else $error("Slave drives clock or master-out pin.");

  master_clock_a: assert property (
    ctrl.module_enable && master |=> pin_oe.sck && pin_owned.sck)
    else $error("Master does not drive the serial clock.");

  fault_flag_a: assert property (
    run && !sclear && fault_now |=> fault_reg && state_reg == SPIF_ST_IDLE)
    else $error("Mode fault not flagged or transfer not stopped.");

  deep_stop_a: assert property (
    run && power.stop_deep |=> state_reg == SPIF_ST_IDLE && !fault_reg && !tq_valid)
    else $error("Deep stop left state behind.");
endmodule : spif_core

`default_nettype wire

/* File: verilog/spif_pkg.sv */
// Shared constants and types of the serial peripheral block with queues.
`default_nettype none

package spif_pkg;

  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int unsigned SPIF_DATA_W        = 16;
  localparam int unsigned SPIF_FIFO_DEPTH    = 4;
  localparam int unsigned SPIF_CLK_PERIOD_PS = 5000;
  localparam int unsigned SPIF_SCK_HALF_NS   = 20;
  localparam int unsigned SPIF_SCK_HALF_CYC  =
    ((SPIF_SCK_HALF_NS * 1000) / SPIF_CLK_PERIOD_PS) < 1 ? 1 :
    ((SPIF_SCK_HALF_NS * 1000) / SPIF_CLK_PERIOD_PS);
  localparam logic [4:0]  SPIF_BITS_BYTE    = 5'h08;
  localparam logic [4:0]  SPIF_BITS_WORD    = 5'h10;
  localparam logic [15:0] SPIF_SHIFT_RESET  = 16'h0000;
  localparam logic [7:0]  SPIF_DIV_RESET    = 8'h00;
  localparam logic [4:0]  SPIF_CNT_RESET    = 5'h00;
  localparam logic [3:0]  SPIF_PINS_RESET   = 4'h0;
  localparam logic [4:0]  SPIF_STATUS_RESET = 5'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [0:0] {
    SPIF_ST_IDLE  = 1'b0,
    SPIF_ST_SHIFT = 1'b1
  } spif_state_type;

  typedef struct packed {
    logic module_enable;
    logic master_mode;
    logic clk_polarity;
    logic bidir_pin_control;
    logic bidir_output_enable;
    logic word_length_select;
    logic stop_in_wait;
    logic mode_fault_enable;
    logic select_output_enable;
    logic queue_mode_enable;
    logic clock_gate_register;
  } spif_ctrl_type;

  typedef struct packed {
    logic wait_mode;
    logic stop_light;
    logic stop_deep;
  } spif_power_type;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } spif_pins_type;

  typedef struct packed {
    logic busy;
    logic rx_full;
    logic tx_empty;
    logic tx_full;
    logic mode_fault;
  } spif_status_type;

endpackage : spif_pkg

`default_nettype wire
